// File: design/masu_top.sv
// Misaligned access split unit: checks, then issues one or two parts.
//
// Overview of operation
// - Only non-naturally aligned accesses split; aligned ones issue once.
// - Translation miss on any part performs nothing before the exception.
// - Walker dirty bits for split halves need not be set together.
// - Accesses writing their own page tables are unpredictable, undetected.
// - Writeback and write-combining attributes fully support misalignment.
// - Plain uncached supported; aligned accesses safe on I/O regions.
// - Parts with differing cache attributes give unpredictable results.
// - Page-crossing accesses with matching attributes complete correctly.
// - Segment-crossing accesses with matching attributes complete correctly.
// - Interrupts and exceptions land wholly before or after the access.
// - Only uncorrectable ECC on later store part may break atomicity; here a bus error there also leaves the low part written.
// - Atomicity is preserved wherever feasible, even on errors.
// - Listed faults and load errors never break atomicity.
// - Machine-check conditions never break atomicity.
// - Resets may cut a store; remaining parts finish where possible.
// - A hung partial store under soft reset times out, then resets.
// - Non-maskable interrupts are delivered only at instruction boundaries.
// - Actually aligned accesses may be atomic to other observers.
// - Parts may issue in any order; here low part, then high part.
// - Every store byte is written exactly once.
// - No read-merge-write of neighbouring bytes; byte enables only.
// - Aligned accesses follow normal ordering rules.
// - Each part honours barrier ordering like an ordinary reference.
`timescale 1ns/1ns
`include "masu_defines.svh"
module masu_top #(
    parameter int AW          = `MASU_ADDR_W,
    parameter int NB          = `MASU_DATA_BYTES,
    parameter int LB          = `MASU_LINE_BYTES,
    parameter int HANG_CYCLES = `MASU_HANG_CYCLES
) (
    input  wire logic                    clock,        // Core clock.
    input  wire logic                    rst,          // Sync reset, high.
    input  wire logic                    ce,           // Clock enable.
    input  wire logic                    soft_reset,   // Soft reset request.
    input  wire logic                    req_valid,    // Access request.
    input  wire logic                    req_store,    // 1 store, 0 load.
    input  wire logic [AW-1:0]           req_addr,     // Start address.
    input  wire logic [$clog2(NB+1)-1:0] req_size,     // Byte count.
    input  wire logic [NB*8-1:0]         req_wdata,    // Store bytes.
    input  wire logic                    xl_hit_lo,    // Low part hit.
    input  wire logic                    xl_hit_hi,    // High part hit.
    input  wire logic                    xl_perm_lo,   // Low part allowed.
    input  wire logic                    xl_perm_hi,   // High part allowed.
    input  wire masu_pkg::masu_attr_t    attr_lo,      // Low attribute.
    input  wire masu_pkg::masu_attr_t    attr_hi,      // High attribute.
    input  wire logic                    io_region_lo, // Low part is I/O.
    input  wire logic                    mem_ready,    // Part accepted.
    input  wire logic                    mem_done,     // Part completed.
    input  wire logic [NB*8-1:0]         mem_rdata,    // Part read bytes.
    input  wire logic                    mem_ecc_err,  // Uncorrectable ECC.
    input  wire logic                    mem_err,      // Bus or cache error.
    input  wire logic                    barrier_req,  // Barrier pending.
    input  wire logic                    nmi_req,      // NMI pending.
    output logic                         req_ready,    // Idle, ready for a request.
    output logic                         mem_valid,    // Part issued.
    output logic [AW-1:0]                mem_addr,     // Part address.
    output logic [NB-1:0]                mem_ben,      // Part byte enables.
    output logic [NB*8-1:0]              mem_wdata,    // Part data.
    output logic                         mem_write,    // Part is a store.
    output logic                         mem_atomic,   // Single-op path.
    output logic                         rsp_valid,    // Access finished.
    output logic [NB*8-1:0]              rsp_rdata,    // Load result.
    output logic                         rsp_miss,     // Translation miss.
    output logic                         rsp_fault,    // Permission fault.
    output logic                         rsp_error,    // Bus or ECC error.
    output logic                         rsp_partial,  // Store cut by ECC.
    output logic                         barrier_ok,   // Barrier may pass.
    output logic                         nmi_take,     // NMI at boundary.
    output logic                         hang_reset    // Soft reset taken: idle or hang timed out.
);
    import masu_pkg::*;
    localparam int SW = $clog2(NB+1);
    localparam int HW = $clog2(HANG_CYCLES+1);

    if (NB < 2 || (NB & (NB-1)) != 0 || LB < NB || (LB & (LB-1)) != 0 ||
        HANG_CYCLES < 1) begin : g_bad_param
        $error("bad NB, LB or HANG_CYCLES");
    end

    masu_state_t            state_q;
    logic [AW-1:0]          addr_q;
    logic [SW-1:0]          size_q;
    logic                   store_q;
    logic [NB*8-1:0]        wdata_q;
    logic                   hi_phase_q;
    logic                   lo_done_q;
    logic [HW-1:0]          hang_q;
    logic                   soft_pend_q;

    masu_part_if #(.AW(AW), .NB(NB)) part ();

    masu_planner #(.AW(AW), .NB(NB), .LB(LB)) u_plan (
        .addr (addr_q),
        .size (size_q),
        .pl   (part)
    );

    // Byte enable mask of n bytes starting at lane zero.
    function automatic logic [NB-1:0] low_mask(input logic [SW-1:0] n);
        logic [NB-1:0] m;
        m = '0;
        for (int i = 0; i < NB; i++) begin
            if (i < int'(n)) m[i] = 1'b1;
        end
        return m;
    endfunction

    // Attribute classes that carry misaligned accesses.
    function automatic logic attr_ok(input masu_attr_t a);
        return (a == `MASU_ATTR_WB) || (a == `MASU_ATTR_UCA) ||
               (a == `MASU_ATTR_UC);
    endfunction

    // Part-level checks, all resolved before anything is committed.
    logic need_hi;
    logic miss_any;
    logic perm_bad;
    always_comb begin
        need_hi  = part.split;
        miss_any = !xl_hit_lo || (need_hi && !xl_hit_hi);
        // Every byte must be permitted; permissions may differ per part.
        perm_bad = !xl_perm_lo || (need_hi && !xl_perm_hi) ||
                   (part.misaligned && !attr_ok(attr_lo));
        // Mixed attributes are left undefined.
    end

    // Main sequence: accept, check all parts, issue, wait, answer.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q    <= MASU_IDLE;
            addr_q     <= '0;
            size_q     <= '0;
            store_q    <= 1'b0;
            wdata_q    <= '0;
            hi_phase_q <= 1'b0;
            lo_done_q  <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                MASU_IDLE: begin
                    hi_phase_q <= 1'b0;
                    lo_done_q  <= 1'b0;
                    if (req_valid && !soft_pend_q) begin
                        addr_q  <= req_addr;
                        size_q  <= req_size;
                        store_q <= req_store;
                        wdata_q <= req_wdata;
                        state_q <= MASU_CHECK;
                    end
                end
                MASU_CHECK: begin
                    // Any fault ends the access with nothing performed.
                    if (miss_any || perm_bad)
                        state_q <= MASU_DONE;
                    else
                        state_q <= MASU_ISSUE;
                end
                MASU_ISSUE: begin
                    if (mem_ready)
                        state_q <= MASU_WAIT;
                end
                MASU_WAIT: begin
                    if (mem_done) begin
                        if (mem_err || mem_ecc_err) begin
                            state_q <= MASU_DONE;
                        end else if (need_hi && !hi_phase_q) begin
                            hi_phase_q <= 1'b1;
                            lo_done_q  <= 1'b1;
                            state_q    <= MASU_ISSUE;
                        end else begin
                            state_q <= MASU_DONE;
                        end
                    end
                end
                MASU_DONE: begin
                    state_q <= MASU_IDLE;
                end
                default: state_q <= MASU_IDLE;
            endcase
        end
    end

    // Only the part's own bytes are enabled: no stale neighbour rewrite.
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_valid  <= 1'b0;
            mem_addr   <= '0;
            mem_ben    <= '0;
            mem_wdata  <= '0;
            mem_write  <= 1'b0;
            mem_atomic <= 1'b0;
        end else if (ce) begin
            if (state_q == MASU_CHECK && !(miss_any || perm_bad) ||
                state_q == MASU_WAIT && mem_done && !mem_err &&
                !mem_ecc_err && need_hi && !hi_phase_q) begin
                mem_valid  <= 1'b1;
                mem_addr   <= (state_q == MASU_WAIT) ? part.hi_addr : addr_q;
                mem_ben    <= (state_q == MASU_WAIT)
                              ? low_mask(SW'(size_q - part.lo_bytes))
                              : low_mask(part.lo_bytes);
                mem_wdata  <= (state_q == MASU_WAIT)
                              ? (wdata_q >> (8 * int'(part.lo_bytes)))
                              : wdata_q;
                mem_write  <= store_q;
                // Aligned requests use the ordinary single operation.
                mem_atomic <= !part.misaligned;
            end else if (mem_valid && mem_ready) begin
                mem_valid <= 1'b0;
            end
        end
    end

    // Load result assembly and answer flags.
    always_ff @(posedge clock) begin
        if (rst) begin
            rsp_valid   <= 1'b0;
            rsp_rdata   <= '0;
            rsp_miss    <= 1'b0;
            rsp_fault   <= 1'b0;
            rsp_error   <= 1'b0;
            rsp_partial <= 1'b0;
        end else if (ce) begin
            rsp_valid <= 1'b0;
            if (state_q == MASU_IDLE) begin
                rsp_miss    <= 1'b0;
                rsp_fault   <= 1'b0;
                rsp_error   <= 1'b0;
                rsp_partial <= 1'b0;
            end
            if (state_q == MASU_CHECK) begin
                rsp_miss  <= miss_any;
                rsp_fault <= !miss_any && perm_bad;
                rsp_valid <= miss_any || perm_bad;
                rsp_rdata <= '0;
            end
            if (state_q == MASU_WAIT && mem_done) begin
                // Result flagged valid after the last good part, or at once on a part error; a failed load answers zero.
                if (!hi_phase_q)
                    rsp_rdata <= mem_rdata;
                else
                    rsp_rdata <= rsp_rdata |
                                 (mem_rdata << (8 * int'(part.lo_bytes)));
                if (mem_err || mem_ecc_err) begin
                    rsp_error   <= 1'b1;
                    rsp_partial <= store_q && lo_done_q && mem_ecc_err;
                    rsp_valid   <= 1'b1;
                    if (!store_q) rsp_rdata <= '0;
                end else if (!(need_hi && !hi_phase_q)) begin
                    rsp_valid <= 1'b1;
                end
            end
        end
    end

    // Barriers and NMIs only pass between whole accesses.
    always_ff @(posedge clock) begin
        if (rst) begin
            barrier_ok <= 1'b0;
            nmi_take   <= 1'b0;
            req_ready  <= 1'b0;
        end else if (ce) begin
            barrier_ok <= barrier_req && state_q == MASU_IDLE;
            nmi_take   <= nmi_req && state_q == MASU_IDLE && !req_valid;
            req_ready  <= state_q == MASU_IDLE && !soft_pend_q;
        end
    end

    // Soft reset lets a store finish; the timer cuts off a hang.
    always_ff @(posedge clock) begin
        if (rst) begin
            soft_pend_q <= 1'b0;
            hang_q      <= '0;
            hang_reset  <= 1'b0;
        end else if (ce) begin
            hang_reset <= 1'b0;
            if (soft_reset)
                soft_pend_q <= 1'b1;
            if (soft_pend_q) begin
                if (state_q == MASU_IDLE ||
                    hang_q == HW'(HANG_CYCLES)) begin
                    soft_pend_q <= 1'b0;
                    hang_reset  <= 1'b1;
                    hang_q      <= '0;
                end else begin
                    hang_q <= hang_q + HW'(1);
                end
            end
        end
    end

    // Dirty bits and own page-table writes lie outside.
    // Machine checks arrive as faults at the check stage.
    logic unused_io;
    assign unused_io = io_region_lo ^ attr_hi[0];
endmodule

// File: design/masu_defines.svh
// Constants for the misaligned access split unit.
`ifndef MASU_DEFINES_SVH
`define MASU_DEFINES_SVH
`define MASU_ADDR_W        32
`define MASU_DATA_BYTES    16
`define MASU_LINE_BYTES    32
`define MASU_HANG_CYCLES   1024
`define MASU_ATTR_WB       3'h2
`define MASU_ATTR_UCA      3'h7
`define MASU_ATTR_UC       3'h0
`endif

// File: design/masu_pkg.sv
// Types shared by the misaligned access split unit.
package masu_pkg;
    typedef logic [2:0] masu_attr_t;
    typedef enum logic [4:0] {
        MASU_IDLE  = 5'b00001,
        MASU_CHECK = 5'b00010,
        MASU_ISSUE = 5'b00100,
        MASU_WAIT  = 5'b01000,
        MASU_DONE  = 5'b10000
    } masu_state_t;
endpackage

// File: design/masu_part_if.sv
// Carrier for the split plan handed from the planner to the sequencer.
`timescale 1ns/1ns
interface masu_part_if #(parameter int AW = 32, parameter int NB = 16);
    logic [AW-1:0]   addr;
    logic [$clog2(NB+1)-1:0] size;
    logic            misaligned;
    logic            split;
    logic [AW-1:0]   hi_addr;
    logic [$clog2(NB+1)-1:0] lo_bytes;
    modport plan (output addr, size, misaligned, split, hi_addr, lo_bytes);
    modport use_ (input addr, size, misaligned, split, hi_addr, lo_bytes);
endinterface

// File: design/masu_planner.sv
// Alignment classification and split-point computation.
`timescale 1ns/1ns
`include "masu_defines.svh"
module masu_planner #(
    parameter int AW = 32,
    parameter int NB = 16,
    parameter int LB = 32
) (
    input  wire logic [AW-1:0]              addr,  // Start address.
    input  wire logic [$clog2(NB+1)-1:0]    size,  // Byte count.
    masu_part_if.plan                       pl     // Split plan out.
);
    localparam int SW = $clog2(NB+1);
    localparam int LW = $clog2(LB);

    // Natural alignment: low address bits under the size must be zero.
    function automatic logic is_aligned(input logic [AW-1:0] a,
                                        input logic [SW-1:0] s);
        logic [AW-1:0] m;
        m = AW'(s) - AW'(1);
        return ((a & m) == '0);
    endfunction

    logic [LW:0] room;
    always_comb begin
        room = (LW+1)'(LB) - {1'b0, addr[LW-1:0]};
        pl.addr       = addr;
        pl.size       = size;
        pl.misaligned = !is_aligned(addr, size);
        // Split when the bytes run past the end of the line.
        pl.split      = pl.misaligned && ({1'b0, room} < (LW+2)'(size));
        pl.lo_bytes   = pl.split ? SW'(room) : size;
        pl.hi_addr    = addr + AW'(room);
    end
endmodule

// File: tb/masu_properties.sv
// Port-level assertions for the misaligned access split unit.
`timescale 1ns/1ns
module masu_props (
    input wire logic        clock,       // Core clock.
    input wire logic        rst,         // Sync reset, high.
    input wire logic        soft_reset,  // Soft reset request.
    input wire logic        req_valid,   // Access request.
    input wire logic        nmi_req,     // NMI pending.
    input wire logic        barrier_req, // Barrier pending.
    input wire logic        mem_valid,   // Part issued.
    input wire logic        mem_ready,   // Part accepted.
    input wire logic [31:0] mem_addr,    // Part address.
    input wire logic [15:0] mem_ben,     // Part byte enables.
    input wire logic        mem_atomic,  // Single-op path.
    input wire logic        rsp_valid,   // Access finished.
    input wire logic        rsp_miss,    // Translation miss.
    input wire logic        rsp_fault,   // Permission fault.
    input wire logic        rsp_error,   // Bus or ECC error.
    input wire logic        rsp_partial, // Store cut by ECC.
    input wire logic        barrier_ok,  // Barrier may pass.
    input wire logic        nmi_take,    // NMI at boundary.
    input wire logic        hang_reset   // Soft reset taken: idle or hang timed out.
);
    logic [1:0] parts_q;
    logic       soft_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Parts accepted in the current access.
    always_ff @(posedge clock) begin
        if (rst || rsp_valid || hang_reset) begin
            parts_q <= 2'h0;
        end else if (mem_valid && mem_ready) begin
            parts_q <= parts_q + 2'h1;
        end
    end

    // Remember a soft reset until its hang pulse.
    always_ff @(posedge clock) begin
        if (rst || hang_reset) begin
            soft_q <= 1'b0;
        end else if (soft_reset) begin
            soft_q <= 1'b1;
        end
    end

    sequence s_fail;
        rsp_valid && (rsp_miss || rsp_fault);
    endsequence
    sequence s_ok;
        rsp_valid && !rsp_miss && !rsp_fault && !rsp_error;
    endsequence

    a_part_held: assert property (mem_valid && !mem_ready |=>
        mem_valid && $stable(mem_addr) && $stable(mem_ben))
        else $error("part changed early");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("long response");
    a_fail_clean: assert property (s_fail |-> parts_q == 2'h0)
        else $error("part before refusal");
    a_fail_time: assert property (s_fail |->
        $past(req_valid, 2) || $past(req_valid, 3))
        else $error("late refusal");
    a_part_count: assert property (s_ok |-> parts_q == 2'h1 ||
        (parts_q == 2'h2 && !mem_atomic))
        else $error("bad part count");
    a_nmi_edge: assert property (nmi_take |-> !mem_valid &&
        $past(nmi_req) && !$past(req_valid))
        else $error("NMI mid-access");
    a_barrier_idle: assert property (barrier_ok |->
        !mem_valid && $past(barrier_req))
        else $error("barrier mid-part");
    a_hang_cause: assert property (hang_reset |-> soft_q ##1 !hang_reset)
        else $error("stray hang pulse");
    a_partial_err: assert property (rsp_valid && rsp_partial |->
        rsp_error && parts_q == 2'h2)
        else $error("stray partial");
endmodule

bind masu_top masu_props u_props (
    .clock, .rst, .soft_reset, .req_valid, .nmi_req, .barrier_req,
    .mem_valid, .mem_ready, .mem_addr, .mem_ben, .mem_atomic, .rsp_valid,
    .rsp_miss, .rsp_fault, .rsp_error, .rsp_partial, .barrier_ok,
    .nmi_take, .hang_reset
);

// File: tb/masu_mem_model.sv
// Behavioural cache and memory behind the split unit's issue port.
`timescale 1ns/1ns
module masu_mem_model (
    input  wire logic         clock,       // Core clock.
    input  wire logic         rst,         // Sync reset, high.
    input  wire logic         mem_valid,   // Part issued.
    input  wire logic [31:0]  mem_addr,    // Part address.
    input  wire logic [15:0]  mem_ben,     // Part byte enables.
    input  wire logic [127:0] mem_wdata,   // Part data.
    input  wire logic         mem_write,   // Part is a store.
    input  wire logic         stall,       // Never complete a part.
    input  wire logic         bad,         // Fail parts at line start.
    output logic              mem_ready,   // Part accepted.
    output logic              mem_done,    // Part completed.
    output logic [127:0]      mem_rdata,   // Part read bytes.
    output logic              mem_ecc_err, // Uncorrectable ECC.
    output logic              mem_err      // Bus error.
);
    logic [7:0]   mem [int unsigned];
    logic [1:0]   ph_q;
    logic [2:0]   cnt_q;
    logic [31:0]  a_q;
    logic [15:0]  b_q;
    logic [127:0] w_q;
    logic         wr_q;

    function automatic logic [7:0] rd(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ 8'ha5;
    endfunction

    // Varying delays; idle read data toggles so stale data never passes.
    always @(posedge clock) begin
        mem_ready <= 1'b0;
        mem_done <= 1'b0;
        mem_ecc_err <= 1'b0;
        mem_err <= 1'b0;
        mem_rdata <= ~mem_rdata;
        cnt_q <= cnt_q + 3'h1;
        if (rst) begin
            ph_q <= 2'h0;
            cnt_q <= 3'h0;
            mem_rdata <= '0;
        end else if (ph_q == 2'h0 && mem_valid) begin
            ph_q <= 2'h1;
        end else if (ph_q == 2'h1 && cnt_q[0]) begin
            mem_ready <= 1'b1;
            a_q <= mem_addr;
            b_q <= mem_ben;
            w_q <= mem_wdata;
            wr_q <= mem_write;
            ph_q <= 2'h2;
        end else if (ph_q == 2'h2 && !stall && cnt_q[1]) begin
            mem_done <= 1'b1;
            ph_q <= 2'h0;
            if (bad && a_q[4:0] == 5'h0) begin
                mem_ecc_err <= wr_q;
                mem_err <= !wr_q;
            end else begin
                for (int i = 0; i < 16; i++) begin
                    if (wr_q && b_q[i]) mem[a_q + i] = w_q[i*8+:8];
                    mem_rdata[i*8+:8] <= rd(a_q + i);
                end
            end
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the misaligned access split unit.
`timescale 1ns/1ns
`include "masu_defines.svh"
module tb;
    import masu_pkg::*;
    typedef struct {
        logic [3:0]   f;
        logic [127:0] d;
        logic [127:0] m;
    } masu_exp_t;

    logic         clock = 1'b0, rst = 1'b1, soft_reset = 1'b0;
    logic         req_valid = 1'b0, req_store = 1'b0, stall = 1'b0;
    logic         xl_hit_lo = 1'b1, xl_hit_hi = 1'b1, bad = 1'b0;
    logic         xl_perm_lo = 1'b1, xl_perm_hi = 1'b1;
    logic         nmi_req = 1'b0, barrier_req = 1'b0;
    logic [4:0]   req_size = 5'h0;
    logic [127:0] req_wdata = '0;
    logic [31:0]  req_addr = 32'h0000_0000, rs = 32'h4384_b88c;
    masu_attr_t   attr_lo = `MASU_ATTR_WB, attr_hi = `MASU_ATTR_WB;
    masu_attr_t   at_tab [3];
    logic         mem_ready, mem_done, mem_ecc_err, mem_err, mem_valid;
    logic         mem_write, mem_atomic, req_ready, rsp_valid, rsp_miss;
    logic         rsp_fault, rsp_error, rsp_partial, barrier_ok;
    logic         nmi_take, hang_reset;
    logic [127:0] mem_rdata, mem_wdata, rsp_rdata;
    logic [31:0]  mem_addr;
    logic [15:0]  mem_ben;
    int           n_errors = 0, num_checks = 0, n;
    masu_exp_t    q[$], m_e;
    logic [7:0]   sh [int unsigned];

    masu_top #(.HANG_CYCLES(8)) u_dut (
        .clock, .rst, .ce(1'b1), .soft_reset, .req_valid, .req_store,
        .req_addr, .req_size, .req_wdata, .xl_hit_lo, .xl_hit_hi,
        .xl_perm_lo, .xl_perm_hi, .attr_lo, .attr_hi,
        .io_region_lo(1'b0),
        .mem_ready, .mem_done, .mem_rdata, .mem_ecc_err, .mem_err,
        .barrier_req, .nmi_req, .req_ready, .mem_valid, .mem_addr,
        .mem_ben, .mem_wdata, .mem_write, .mem_atomic, .rsp_valid,
        .rsp_rdata, .rsp_miss, .rsp_fault, .rsp_error, .rsp_partial,
        .barrier_ok, .nmi_take, .hang_reset
    );
    masu_mem_model u_mem (
        .clock, .rst, .mem_valid, .mem_addr, .mem_ben, .mem_wdata,
        .mem_write, .stall, .bad, .mem_ready, .mem_done, .mem_rdata,
        .mem_ecc_err, .mem_err
    );

    // Clock at 20 MHz.
    always #25 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] rd(input logic [31:0] a);
        return sh.exists(a) ? sh[a] : a[7:0] ^ 8'ha5;
    endfunction

    // Case inequality, so unknowns never match.
    task automatic chk_d(input logic [127:0] e, input logic [127:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_f(input logic [3:0] e, input logic [3:0] g);
        chk_d({124'h0, e}, {124'h0, g});
    endtask

    // One access: note the answer, hold the request for one edge.
    task automatic run(input logic st, input logic [31:0] a,
                       input logic [4:0] sz, input logic [3:0] fl);
        masu_exp_t    e;
        logic [127:0] wd;
        rs = lfsr(rs);
        wd = {rs, ~rs, rs ^ 32'h5a5a_5a5a, rs + 32'h0000_0001};
        e.f = fl;
        e.d = '0;
        e.m = '0;
        for (int i = 0; i < sz; i++) begin
            if (!st && fl == 4'h0) begin
                e.m[i*8+:8] = 8'hff;
                e.d[i*8+:8] = rd(a + i);
            end
            if (st && (fl == 4'h0 || (fl == 4'hc && i < 32 - a[4:0])))
                sh[a + i] = wd[i*8+:8];
        end
        q.push_back(e);
        for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(posedge clock);
        if (n == 200) n_errors++;
        req_valid <= 1'b1;
        req_store <= st;
        req_addr <= a;
        req_size <= sz;
        req_wdata <= wd;
        @(posedge clock);
        req_valid <= 1'b0;
        for (n = 0; n < 200 && rsp_valid !== 1'b1; n++) @(posedge clock);
        if (n == 200) n_errors++;
        @(posedge clock);
    endtask

    // Match each response against the oldest note.
    always @(posedge clock) begin
        if (!rst && rsp_valid === 1'b1) begin
            if (q.size() == 0) begin
                n_errors++;
                $display("CHECK FAILED t=%0t exp=%h got=%h", $time, 0, 1);
            end else begin
                m_e = q.pop_front();
                chk_f(m_e.f, {rsp_partial, rsp_error, rsp_fault, rsp_miss});
                chk_d(m_e.d, rsp_rdata & m_e.m);
            end
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog, far longer than the tests need.
    initial begin
        repeat (30000) @(posedge clock);
        n_errors++;
        conclude();
    end

    // Main sequence.
    initial begin
        at_tab = '{`MASU_ATTR_WB, `MASU_ATTR_UCA, `MASU_ATTR_UC};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        // Random traffic over a line and page edge.
        for (int k = 0; k < 60; k++) begin
            rs = lfsr(rs);
            attr_lo <= at_tab[rs[14:13] % 2'h3];
            attr_hi <= at_tab[rs[14:13] % 2'h3];
            nmi_req <= rs[9];
            barrier_req <= rs[8];
            run(rs[0], 32'h0000_0fc0 + {25'h0, rs[7:1]},
                5'h1 << (rs[12:10] % 3'h5), 4'h0);
        end
        $display("random traffic done");
        // Refusals: unmapped high half, then forbidden low half.
        xl_hit_hi <= 1'b0;
        run(1'b1, 32'h0000_0ffa, 5'h8, 4'h1);
        xl_hit_hi <= 1'b1;
        xl_perm_lo <= 1'b0;
        run(1'b1, 32'h0000_0ffa, 5'h8, 4'h2);
        xl_perm_lo <= 1'b1;
        attr_lo <= 3'h1;
        run(1'b0, 32'h0000_0ffa, 5'h8, 4'h2);
        attr_lo <= `MASU_ATTR_WB;
        run(1'b0, 32'h0000_0ff8, 5'h10, 4'h0);
        $display("refusal tests done");
        // Errors on the later part of split accesses.
        bad <= 1'b1;
        run(1'b1, 32'h0000_0ff6, 5'h10, 4'hc);
        run(1'b0, 32'h0000_0ff6, 5'h10, 4'h4);
        bad <= 1'b0;
        run(1'b0, 32'h0000_0ff0, 5'h10, 4'h0);
        run(1'b0, 32'h0000_1000, 5'h10, 4'h0);
        $display("error tests done");
        // NMI and barrier pass only while idle.
        nmi_req <= 1'b1;
        barrier_req <= 1'b1;
        repeat (3) @(posedge clock);
        chk_f(4'h3, {2'h0, barrier_ok, nmi_take});
        nmi_req <= 1'b0;
        barrier_req <= 1'b0;
        // Stalled store: soft reset must time out.
        stall <= 1'b1;
        req_valid <= 1'b1;
        req_store <= 1'b1;
        req_addr <= 32'h0000_0ffa;
        @(posedge clock);
        req_valid <= 1'b0;
        repeat (8) @(posedge clock);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        for (n = 0; n < 100 && hang_reset !== 1'b1; n++) @(posedge clock);
        chk_f({3'h0, hang_reset}, 4'h1);
        rst <= 1'b1;
        stall <= 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        $display("hang test done");
        conclude();
    end
endmodule
